// ### hdl/pfm_pkg.sv
// Package of constants and state type for the port pin function mux
package pfm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] A_P2_DATA = 4'h0;
    localparam logic [3:0] A_P2_DIR  = 4'h1;
    localparam logic [3:0] A_P2_PU   = 4'h2;
    localparam logic [3:0] A_P2_CTRL = 4'h3;
    localparam logic [3:0] A_P3_DATA = 4'h4;
    localparam logic [3:0] A_P3_DIR  = 4'h5;
    localparam logic [3:0] A_P3_PU   = 4'h6;
    localparam logic [3:0] A_P3_CTRL = 4'h7;
    localparam logic [3:0] A_P4_DATA = 4'h8;
    localparam logic [3:0] A_P4_DIR  = 4'h9;
    localparam logic [3:0] A_P4_PU   = 4'ha;
    localparam logic [3:0] A_EDGE    = 4'hc;
    localparam logic [3:0] A_STAT    = 4'hd;
    localparam logic [3:0] A_MASK    = 4'he;
    localparam logic [3:0] A_OPT     = 4'hf;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OPT_OSC   = 0;
    localparam int OPT_RPORT = 1;
    localparam int OPT_TBO   = 2;
    localparam int OPT_TAO   = 3;
    localparam int OPT_ANA   = 4;
    localparam int EDG_AR    = 0;
    localparam int EDG_AF    = 1;
    localparam int EDG_BR    = 2;
    localparam int EDG_BF    = 3;
    localparam int IRQ_A     = 0;
    localparam int IRQ_B     = 1;
    localparam int PIN_TCLK  = 0;
    localparam int PIN_TBO   = 0;
    localparam int PIN_TCAP  = 1;
    localparam int PIN_TAO   = 1;
    localparam int PIN_IRQA  = 1;
    localparam int PIN_XOUT  = 2;
    localparam int PIN_XIN   = 3;
    localparam int P3_RBIT   = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] P2_DIR_RST = 4'hf;
    localparam logic       P3_DIR_RST = 1'h1;
    localparam logic [7:0] P4_DIR_RST = 8'hff;
    localparam logic       RPIN_RST   = 1'h1;

    typedef struct packed {
        logic [3:0] p2_out;
        logic [3:0] p2_dir;
        logic [3:0] p2_pu;
        logic [3:0] p2_ctrl;
        logic       p3_out;
        logic       p3_dir;
        logic       p3_pu;
        logic       p3_ctrl;
        logic [7:0] p4_out;
        logic [7:0] p4_dir;
        logic [7:0] p4_pu;
        logic [3:0] edge_cfg;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [7:0] opt;
        logic [3:0] p2_s1;
        logic [3:0] p2_s2;
        logic [3:0] p2_s3;
        logic       p3_s1;
        logic       p3_s2;
        logic       p3_s3;
        logic       rp_s1;
        logic       rp_s2;
        logic [7:0] p4_s1;
        logic [7:0] p4_s2;
        logic [3:0] p2_o;
        logic [3:0] p2_oe;
        logic [3:0] p2_pue;
        logic       p2_pd;
        logic [3:0] ana_en;
        logic       p3_o;
        logic       p3_oe;
        logic       p3_pue;
        logic [7:0] p4_o;
        logic [7:0] p4_oe;
        logic [7:0] p4_pue;
        logic       ta_clk;
        logic       cap_a_clk;
        logic       cap_a_cap;
        logic       cap_b;
        logic       osc_clk;
        logic       sys_req;
        logic       irq;
        logic [7:0] rdata;
    } pfm_state_t;

endpackage : pfm_pkg

// ### hdl/pfm_port_mux.sv
// Port pin function mux: port 2, 3, 4 logic, alternate functions, interrupts
//
// Behaviour
// - Each port_2 pin is set alone to port mode or control mode.
// - Port mode port_2: per-bit direction and pull-up from their registers.
// - port3_io_pin is one I/O bit with direction and pull-up registers.
// - port3_input_pin as port is input only, never driven.
// - After reset the shared input pin is the reset input.
// - Low on the reset pin requests a system reset.
// - port_4 is 8-bit I/O with per-bit direction and pull-up.
// - ext_irq_a and ext_irq_b detect rising, falling or both edges.
// - Control mode routes port3_io_pin as ext_irq_b, port_2 pin as ext_irq_a.
// - timer_a_clk_cap_in feeds timer_a count clock and both captures.
// - timer_a_cap_in feeds only capture_reg_a.
// - Alternate output drives timer_a_out and timer_b_out onto their pins.
// - Analog mode connects port_2 pins as analog_in_0_to_3.
// - The two oscillator pins are pulled down during reset.
// - Oscillator mode makes them osc_in and osc_out; clock enters osc_in.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module pfm_port_mux (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    // Port 2 pins
    input  wire logic [3:0] port2_in,
    output var  logic [3:0] port2_out,
    output var  logic [3:0] port2_oe,
    output var  logic [3:0] port2_pullup_en,
    output var  logic       osc_pins_pulldown_en,
    output var  logic [3:0] analog_in_en,
    // Port 3 pins
    input  wire logic       port3_io_in,
    output var  logic       port3_io_out,
    output var  logic       port3_io_oe,
    output var  logic       port3_io_pullup_en,
    input  wire logic       port3_input_pin,
    // Port 4 pins
    input  wire logic [7:0] port4_in,
    output var  logic [7:0] port4_out,
    output var  logic [7:0] port4_oe,
    output var  logic [7:0] port4_pullup_en,
    // Timer side
    input  wire logic       timer_a_out,
    input  wire logic       timer_b_out,
    output var  logic       timer_a_count_clk,
    output var  logic       cap_a_trig_clk_pin,
    output var  logic       cap_a_trig_cap_pin,
    output var  logic       cap_b_trig,
    // Oscillator and system
    input  wire logic       osc_drive,
    output var  logic       osc_in_clk,
    output var  logic       sys_reset_req,
    output var  logic       irq
);

    pfm_pkg::pfm_state_t r;
    pfm_pkg::pfm_state_t next_r;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [1:0] ev;
    logic [1:0] clr;
    logic       a_rise;
    logic       a_fall;
    logic       b_rise;
    logic       b_fall;
    logic       osc;
    logic [3:0] p2_rd;
    logic [3:0] p2_ana;

    always_comb begin
        next_r = r;
        ev     = 2'h0;
        clr    = 2'h0;
        osc    = 1'h0;
        p2_rd  = 4'h0;
        p2_ana = 4'h0;
        a_rise = 1'h0;
        a_fall = 1'h0;
        b_rise = 1'h0;
        b_fall = 1'h0;

        // Synchronisers; stage one feeds stage two only
        next_r.p2_s1 = port2_in;
        next_r.p2_s2 = r.p2_s1;
        next_r.p2_s3 = r.p2_s2;
        next_r.p3_s1 = port3_io_in;
        next_r.p3_s2 = r.p3_s1;
        next_r.p3_s3 = r.p3_s2;
        next_r.rp_s1 = port3_input_pin;
        next_r.rp_s2 = r.rp_s1;
        next_r.p4_s1 = port4_in;
        next_r.p4_s2 = r.p4_s1;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                pfm_pkg::A_P2_DATA: next_r.p2_out = reg_wdata[3:0];
                pfm_pkg::A_P2_DIR:  next_r.p2_dir = reg_wdata[3:0];
                pfm_pkg::A_P2_PU:   next_r.p2_pu = reg_wdata[3:0];
                pfm_pkg::A_P2_CTRL: next_r.p2_ctrl = reg_wdata[3:0];
                pfm_pkg::A_P3_DATA: next_r.p3_out = reg_wdata[0];
                pfm_pkg::A_P3_DIR:  next_r.p3_dir = reg_wdata[0];
                pfm_pkg::A_P3_PU:   next_r.p3_pu = reg_wdata[0];
                pfm_pkg::A_P3_CTRL: next_r.p3_ctrl = reg_wdata[0];
                pfm_pkg::A_P4_DATA: next_r.p4_out = reg_wdata;
                pfm_pkg::A_P4_DIR:  next_r.p4_dir = reg_wdata;
                pfm_pkg::A_P4_PU:   next_r.p4_pu = reg_wdata;
                pfm_pkg::A_EDGE:    next_r.edge_cfg = reg_wdata[3:0];
                pfm_pkg::A_STAT:    clr = reg_wdata[1:0];
                pfm_pkg::A_MASK:    next_r.irq_mask = reg_wdata[1:0];
                pfm_pkg::A_OPT:     next_r.opt = reg_wdata;
                default: ;
            endcase
        end

        // Edge detection on synchronised levels
        a_rise = r.p2_s2[pfm_pkg::PIN_IRQA] & ~r.p2_s3[pfm_pkg::PIN_IRQA];
        a_fall = ~r.p2_s2[pfm_pkg::PIN_IRQA] & r.p2_s3[pfm_pkg::PIN_IRQA];
        b_rise = r.p3_s2 & ~r.p3_s3;
        b_fall = ~r.p3_s2 & r.p3_s3;
        ev[pfm_pkg::IRQ_A] = r.p2_ctrl[pfm_pkg::PIN_IRQA]
            & ((a_rise & r.edge_cfg[pfm_pkg::EDG_AR])
             | (a_fall & r.edge_cfg[pfm_pkg::EDG_AF]));
        ev[pfm_pkg::IRQ_B] = r.p3_ctrl
            & ((b_rise & r.edge_cfg[pfm_pkg::EDG_BR])
             | (b_fall & r.edge_cfg[pfm_pkg::EDG_BF]));
        // Set beats a same-cycle clear so no edge is lost
        next_r.irq_stat = (r.irq_stat & ~clr) | ev;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

        // Port 2 pin control, from the freshly written configuration
        osc = next_r.opt[pfm_pkg::OPT_OSC];
        p2_ana = next_r.p2_ctrl & next_r.opt[pfm_pkg::OPT_ANA +: 4];
        if (osc) begin
            p2_ana[pfm_pkg::PIN_XOUT] = 1'h0;
            p2_ana[pfm_pkg::PIN_XIN]  = 1'h0;
        end
        next_r.ana_en = p2_ana;
        next_r.p2_o   = next_r.p2_out;
        next_r.p2_oe  = ~next_r.p2_dir & ~next_r.p2_ctrl;
        next_r.p2_pue = next_r.p2_pu & next_r.p2_dir & ~next_r.p2_ctrl;
        // Alternate outputs take the pin in control mode
        if (next_r.p2_ctrl[pfm_pkg::PIN_TBO] && next_r.opt[pfm_pkg::OPT_TBO]) begin
            next_r.p2_o[pfm_pkg::PIN_TBO]  = timer_b_out;
            next_r.p2_oe[pfm_pkg::PIN_TBO] = 1'h1;
        end
        if (next_r.p2_ctrl[pfm_pkg::PIN_TAO] && next_r.opt[pfm_pkg::OPT_TAO]) begin
            next_r.p2_o[pfm_pkg::PIN_TAO]  = timer_a_out;
            next_r.p2_oe[pfm_pkg::PIN_TAO] = 1'h1;
        end
        // Oscillator use overrides both port and control mode
        if (osc) begin
            next_r.p2_o[pfm_pkg::PIN_XOUT]   = osc_drive;
            next_r.p2_oe[pfm_pkg::PIN_XOUT]  = 1'h1;
            next_r.p2_oe[pfm_pkg::PIN_XIN]   = 1'h0;
            next_r.p2_pue[pfm_pkg::PIN_XOUT] = 1'h0;
            next_r.p2_pue[pfm_pkg::PIN_XIN]  = 1'h0;
        end
        // Analog pins have the digital driver off
        next_r.p2_oe  = next_r.p2_oe & ~p2_ana;
        next_r.p2_pue = next_r.p2_pue & ~p2_ana;
        next_r.osc_clk = osc & r.p2_s2[pfm_pkg::PIN_XIN];
        // Hold oscillator pins low while reset is requested
        next_r.p2_pd = r.sys_req;

        // Timer inputs
        next_r.ta_clk = r.p2_ctrl[pfm_pkg::PIN_TCLK]
                      & r.p2_s2[pfm_pkg::PIN_TCLK];
        next_r.cap_a_clk = next_r.ta_clk;
        next_r.cap_b     = next_r.ta_clk;
        next_r.cap_a_cap = r.p2_ctrl[pfm_pkg::PIN_TCAP]
                         & r.p2_s2[pfm_pkg::PIN_TCAP];

        // Port 3
        next_r.p3_o   = next_r.p3_out;
        next_r.p3_oe  = ~next_r.p3_dir & ~next_r.p3_ctrl;
        next_r.p3_pue = next_r.p3_pu & next_r.p3_dir & ~next_r.p3_ctrl;

        // Port 4
        next_r.p4_o   = next_r.p4_out;
        next_r.p4_oe  = ~next_r.p4_dir;
        next_r.p4_pue = next_r.p4_pu & next_r.p4_dir;

        // Reset pin is active low unless released to port use
        next_r.sys_req = ~r.rp_s2 & ~r.opt[pfm_pkg::OPT_RPORT];

        // Read data; inputs show the pin, outputs show the latch
        p2_rd = (r.p2_s2 & r.p2_dir) | (r.p2_out & ~r.p2_dir);
        next_r.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                pfm_pkg::A_P2_DATA: next_r.rdata = {4'h0, p2_rd & ~p2_ana};
                pfm_pkg::A_P2_DIR:  next_r.rdata = {4'h0, r.p2_dir};
                pfm_pkg::A_P2_PU:   next_r.rdata = {4'h0, r.p2_pu};
                pfm_pkg::A_P2_CTRL: next_r.rdata = {4'h0, r.p2_ctrl};
                pfm_pkg::A_P3_DATA: begin
                    next_r.rdata[0] = r.p3_dir ? r.p3_s2 : r.p3_out;
                    next_r.rdata[pfm_pkg::P3_RBIT] =
                        r.opt[pfm_pkg::OPT_RPORT] & r.rp_s2;
                end
                pfm_pkg::A_P3_DIR:  next_r.rdata = {7'h00, r.p3_dir};
                pfm_pkg::A_P3_PU:   next_r.rdata = {7'h00, r.p3_pu};
                pfm_pkg::A_P3_CTRL: next_r.rdata = {7'h00, r.p3_ctrl};
                pfm_pkg::A_P4_DATA: next_r.rdata = (r.p4_s2 & r.p4_dir)
                                                 | (r.p4_out & ~r.p4_dir);
                pfm_pkg::A_P4_DIR:  next_r.rdata = r.p4_dir;
                pfm_pkg::A_P4_PU:   next_r.rdata = r.p4_pu;
                pfm_pkg::A_EDGE:    next_r.rdata = {4'h0, r.edge_cfg};
                pfm_pkg::A_STAT:    next_r.rdata = {6'h00, r.irq_stat};
                pfm_pkg::A_MASK:    next_r.rdata = {6'h00, r.irq_mask};
                pfm_pkg::A_OPT:     next_r.rdata = r.opt;
                default:            next_r.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r        <= '0;
            r.p2_dir <= pfm_pkg::P2_DIR_RST;
            r.p3_dir <= pfm_pkg::P3_DIR_RST;
            r.p4_dir <= pfm_pkg::P4_DIR_RST;
            r.rp_s1  <= pfm_pkg::RPIN_RST;
            r.rp_s2  <= pfm_pkg::RPIN_RST;
            r.p2_pd  <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata            = r.rdata;
    assign port2_out            = r.p2_o;
    assign port2_oe             = r.p2_oe;
    assign port2_pullup_en      = r.p2_pue;
    assign osc_pins_pulldown_en = r.p2_pd;
    assign analog_in_en         = r.ana_en;
    assign port3_io_out         = r.p3_o;
    assign port3_io_oe          = r.p3_oe;
    assign port3_io_pullup_en   = r.p3_pue;
    assign port4_out            = r.p4_o;
    assign port4_oe             = r.p4_oe;
    assign port4_pullup_en      = r.p4_pue;
    assign timer_a_count_clk    = r.ta_clk;
    assign cap_a_trig_clk_pin   = r.cap_a_clk;
    assign cap_a_trig_cap_pin   = r.cap_a_cap;
    assign cap_b_trig           = r.cap_b;
    assign osc_in_clk           = r.osc_clk;
    assign sys_reset_req        = r.sys_req;
    assign irq                  = r.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_p2_dir_wr;
        reg_wr && reg_addr == pfm_pkg::A_P2_DIR && r.p2_ctrl == 4'h0
            && !r.opt[pfm_pkg::OPT_OSC];
    endsequence

    property p_r2;
        @(posedge core_clk) disable iff (rst)
        s_p2_dir_wr |=> port2_oe == ~$past(reg_wdata[3:0]);
    endproperty
    a_r2: assert property (p_r2) else $error("port2 oe wrong");

    property p_r1;
        @(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == pfm_pkg::A_P2_CTRL && reg_wdata[0]
            |=> !port2_pullup_en[0];
    endproperty
    a_r1: assert property (p_r1) else $error("pull-up in control");

    property p_r3;
        @(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == pfm_pkg::A_P3_DIR && !r.p3_ctrl
            |=> port3_io_oe == !$past(reg_wdata[0]);
    endproperty
    a_r3: assert property (p_r3) else $error("port3 oe wrong");

    property p_r4;
        @(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == pfm_pkg::A_P3_DATA && r.opt[pfm_pkg::OPT_RPORT]
            |=> reg_rdata[pfm_pkg::P3_RBIT] == $past(r.rp_s2);
    endproperty
    a_r4: assert property (p_r4) else $error("input pin read");

    property p_r5;
        @(posedge core_clk) disable iff (rst)
        $fell(rst) |-> !r.opt[pfm_pkg::OPT_RPORT];
    endproperty
    a_r5: assert property (p_r5) else $error("reset fn lost");

    sequence s_rpin_low;
        !r.rp_s2 && !r.opt[pfm_pkg::OPT_RPORT];
    endsequence

    property p_r6;
        @(posedge core_clk) disable iff (rst)
        s_rpin_low |=> sys_reset_req ##1 osc_pins_pulldown_en;
    endproperty
    a_r6: assert property (p_r6) else $error("reset req missed");

    property p_r7;
        @(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == pfm_pkg::A_P4_DIR
            |=> port4_oe == ~$past(reg_wdata);
    endproperty
    a_r7: assert property (p_r7) else $error("port4 oe wrong");

    sequence s_a_rise;
        $rose(r.p2_s2[pfm_pkg::PIN_IRQA]) && r.p2_ctrl[pfm_pkg::PIN_IRQA]
            && r.edge_cfg[pfm_pkg::EDG_AR];
    endsequence

    property p_r8;
        @(posedge core_clk) disable iff (rst)
        s_a_rise |=> r.irq_stat[pfm_pkg::IRQ_A];
    endproperty
    a_r8: assert property (p_r8) else $error("irq a missed");

    property p_r9;
        @(posedge core_clk) disable iff (rst)
        $fell(r.p3_s2) && r.p3_ctrl && r.edge_cfg[pfm_pkg::EDG_BF]
            |=> r.irq_stat[pfm_pkg::IRQ_B];
    endproperty
    a_r9: assert property (p_r9) else $error("irq b missed");

    property p_r10;
        @(posedge core_clk) disable iff (rst)
        r.p2_ctrl[pfm_pkg::PIN_TCLK] && r.p2_s2[pfm_pkg::PIN_TCLK]
            |=> timer_a_count_clk && cap_b_trig && cap_a_trig_clk_pin;
    endproperty
    a_r10: assert property (p_r10) else $error("timer clk pin");

    property p_r11;
        @(posedge core_clk) disable iff (rst)
        !r.p2_ctrl[pfm_pkg::PIN_TCLK] |=> !cap_b_trig && !timer_a_count_clk;
    endproperty
    a_r11: assert property (p_r11) else $error("cap pin leak");

    property p_r16;
        @(posedge core_clk) disable iff (rst)
        $fell(rst) |-> port2_oe == 4'h0 && !port3_io_oe && port4_oe == 8'h00;
    endproperty
    a_r16: assert property (p_r16) else $error("driven after reset");

endmodule : pfm_port_mux

`default_nettype wire

// ### tb/pfm_pin_model.sv
// Board-side model that resolves the level of each pad from all its drivers
`timescale 1ns/1ns
`default_nettype none

module pfm_pin_model #(
    parameter int W = 4
) (
    // Clock
    input  wire logic         core_clk,
    // Device side
    input  wire logic [W-1:0] o,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pu,
    input  wire logic [W-1:0] pd,
    // Board side
    input  wire logic [W-1:0] ext,
    input  wire logic [W-1:0] ext_en,
    output var  logic [W-1:0] pin
);
    // ----------------------------------------
    // Pad resolution
    // ----------------------------------------
    logic [W-1:0] float_q = '0;

    // Floating pads toggle so a stale level never passes for a drive
    always_ff @(posedge core_clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i]) pin[i] = o[i];
            else if (ext_en[i]) pin[i] = ext[i];
            else if (pu[i]) pin[i] = 1'h1;
            else if (pd[i]) pin[i] = 1'h0;
            else pin[i] = float_q[i];
        end
    end
endmodule : pfm_pin_model

`default_nettype wire

// ### tb/tb_pfm_port_mux.sv
// Self-checking testbench for the port pin function mux
`timescale 1ns/1ns
`default_nettype none

module tb_pfm_port_mux;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic       core_clk = 1'h0;
    logic       rst = 1'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'h0;
    logic       reg_rd = 1'h0;
    logic [7:0] reg_rdata, port4_in, port4_out, port4_oe, port4_pullup_en;
    logic [3:0] port2_in, port2_out, port2_oe, port2_pullup_en, analog_in_en, tins;
    logic       osc_pins_pulldown_en, port3_io_in, port3_io_out, port3_io_oe;
    logic       port3_io_pullup_en, timer_a_count_clk, cap_a_trig_clk_pin;
    logic       cap_a_trig_cap_pin, cap_b_trig, osc_in_clk, sys_reset_req, irq;
    logic       port3_input_pin = 1'h1;
    logic       timer_a_out = 1'h0;
    logic       timer_b_out = 1'h0;
    logic       osc_drive = 1'h0;
    logic [3:0] e2 = 4'h0;
    logic [3:0] en2 = 4'h0;
    logic       e3 = 1'h0;
    logic       en3 = 1'h0;
    logic [7:0] e4 = 8'h00;
    logic [7:0] en4 = 8'h00;
    int         fails = 0;
    int         num_checks = 0;

    assign tins = {cap_b_trig, cap_a_trig_cap_pin, cap_a_trig_clk_pin, timer_a_count_clk};

    always #5 core_clk = ~core_clk;

    pfm_port_mux pfm_port_mux_inst (
        .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .port2_in, .port2_out, .port2_oe, .port2_pullup_en, .osc_pins_pulldown_en,
        .analog_in_en, .port3_io_in, .port3_io_out, .port3_io_oe, .port3_io_pullup_en,
        .port3_input_pin, .port4_in, .port4_out, .port4_oe, .port4_pullup_en,
        .timer_a_out, .timer_b_out, .timer_a_count_clk, .cap_a_trig_clk_pin,
        .cap_a_trig_cap_pin, .cap_b_trig, .osc_drive, .osc_in_clk, .sys_reset_req, .irq);
    pfm_pin_model #(.W(4)) pfm_pin_model_inst2 (.core_clk, .o(port2_out), .oe(port2_oe),
        .pu(port2_pullup_en), .pd({{2{osc_pins_pulldown_en}}, 2'h0}), .ext(e2),
        .ext_en(en2), .pin(port2_in));
    pfm_pin_model #(.W(1)) pfm_pin_model_inst3 (.core_clk, .o(port3_io_out),
        .oe(port3_io_oe), .pu(port3_io_pullup_en), .pd(1'h0), .ext(e3), .ext_en(en3),
        .pin(port3_io_in));
    pfm_pin_model #(.W(8)) pfm_pin_model_inst4 (.core_clk, .o(port4_out), .oe(port4_oe),
        .pu(port4_pullup_en), .pd(8'h00), .ext(e4), .ext_en(en4), .pin(port4_in));

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
        @(posedge core_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        chk(nm, exp, reg_rdata);
    endtask : rd

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    task automatic t_port;
        rd(pfm_pkg::A_P2_DIR, 8'h0f, "p2 dir");
        rd(pfm_pkg::A_P3_DIR, 8'h01, "p3 dir");
        rd(pfm_pkg::A_P4_DIR, 8'hff, "p4 dir");
        chk("oe idle", 8'h00, {3'h0, port3_io_oe, port2_oe} | port4_oe);
        chk("pulldown off", 8'h00, {7'h0, osc_pins_pulldown_en});
        wr(4'hb, 8'hff);
        rd(4'hb, 8'h00, "unmapped");
        wr(pfm_pkg::A_P2_DIR, 8'h0a);
        wr(pfm_pkg::A_P2_DATA, 8'h0f);
        wr(pfm_pkg::A_P2_PU, 8'h0f);
        @(posedge core_clk);
        en2 <= 4'ha;
        e2  <= 4'h2;
        settle(4);
        chk("p2 drive", 8'h55, {port2_oe, port2_out & port2_oe});
        chk("p2 pu", 8'h0a, {4'h0, port2_pullup_en});
        rd(pfm_pkg::A_P2_DATA, 8'h07, "p2 data");
        wr(pfm_pkg::A_P2_CTRL, 8'h02);
        settle(2);
        chk("p2 pu ctrl", 8'h08, {4'h0, port2_pullup_en});
        wr(pfm_pkg::A_P2_DIR, 8'h0f);
        wr(pfm_pkg::A_P4_DIR, 8'h0f);
        wr(pfm_pkg::A_P4_DATA, 8'ha5);
        wr(pfm_pkg::A_P4_PU, 8'hff);
        @(posedge core_clk);
        en4 <= 8'h0f;
        e4  <= 8'h03;
        settle(4);
        chk("p4 oe", 8'hf0, port4_oe);
        chk("p4 out pu", 8'haf, (port4_out & port4_oe) | port4_pullup_en);
        rd(pfm_pkg::A_P4_DATA, 8'ha3, "p4 data");
        $display("test ports done");
    endtask : t_port

    task automatic t_port3;
        wr(pfm_pkg::A_P3_DIR, 8'h00);
        wr(pfm_pkg::A_P3_DATA, 8'h01);
        settle(2);
        chk("p3 drive", 8'h03, {6'h0, port3_io_oe, port3_io_out});
        wr(pfm_pkg::A_P3_DIR, 8'h01);
        wr(pfm_pkg::A_P3_PU, 8'h01);
        settle(2);
        chk("p3 pu", 8'h01, {6'h0, port3_io_oe, port3_io_pullup_en});
        @(posedge core_clk);
        port3_input_pin <= 1'h0;
        settle(5);
        chk("rst req", 8'h03, {6'h0, sys_reset_req, osc_pins_pulldown_en});
        @(posedge core_clk);
        port3_input_pin <= 1'h1;
        wr(pfm_pkg::A_OPT, 8'h02);
        @(posedge core_clk);
        port3_input_pin <= 1'h0;
        settle(5);
        chk("port use", 8'h00, {7'h0, sys_reset_req});
        rd(pfm_pkg::A_P3_DATA, 8'h01, "p3 in low");
        @(posedge core_clk);
        port3_input_pin <= 1'h1;
        settle(4);
        rd(pfm_pkg::A_P3_DATA, 8'h03, "p3 in high");
        $display("test port3 done");
    endtask : t_port3

    task automatic t_irq;
        int b;
        @(posedge core_clk);
        en2 <= 4'h2;
        e2  <= 4'h0;
        en3 <= 1'h1;
        wr(pfm_pkg::A_P3_CTRL, 8'h01);
        wr(pfm_pkg::A_MASK, 8'h03);
        for (int ch = 0; ch < 2; ch++) begin
            for (int m = 1; m < 4; m++) begin
                wr(pfm_pkg::A_EDGE, 8'(m << (2 * ch)));
                settle(2);
                wr(pfm_pkg::A_STAT, 8'h03);
                for (int v = 1; v >= 0; v--) begin
                    b = (v != 0 ? m : m >> 1) & 1;
                    @(posedge core_clk);
                    if (ch == 0) e2[1] <= v[0];
                    else e3 <= v[0];
                    settle(6);
                    rd(pfm_pkg::A_STAT, 8'(b << ch), "irq stat");
                    chk("irq", 8'(b), {7'h0, irq});
                    wr(pfm_pkg::A_STAT, 8'h03);
                end
            end
        end
        wr(pfm_pkg::A_MASK, 8'h00);
        @(posedge core_clk);
        e3 <= 1'h1;
        settle(6);
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(pfm_pkg::A_MASK, 8'h02);
        settle(2);
        chk("irq unmasked", 8'h01, {7'h0, irq});
        wr(pfm_pkg::A_STAT, 8'h02);
        settle(2);
        chk("irq cleared", 8'h00, {7'h0, irq});
        $display("test irq done");
    endtask : t_irq

    task automatic t_alt;
        wr(pfm_pkg::A_P2_CTRL, 8'h03);
        @(posedge core_clk);
        en2 <= 4'h3;
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            e2 <= (k != 0) ? 4'h2 : 4'h1;
            settle(4);
            chk("timer in", (k != 0) ? 8'h04 : 8'h0b, {4'h0, tins});
        end
        @(posedge core_clk);
        en2 <= 4'h0;
        wr(pfm_pkg::A_OPT, 8'h0c);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            timer_a_out <= k[0];
            timer_b_out <= ~k[0];
            settle(3);
            chk("timer out", (k != 0) ? 8'h32 : 8'h31,
                {2'h0, port2_oe[1:0], 2'h0, port2_out[1:0]});
        end
        wr(pfm_pkg::A_P2_CTRL, 8'h0f);
        wr(pfm_pkg::A_OPT, 8'hf0);
        settle(2);
        chk("analog", 8'h0f, {port2_oe, analog_in_en});
        rd(pfm_pkg::A_P2_DATA, 8'h00, "analog data");
        wr(pfm_pkg::A_OPT, 8'h51);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            osc_drive <= ~k[0];
            en2 <= 4'h8;
            e2  <= {~k[0], 3'h0};
            settle(4);
            chk("osc", (k != 0) ? 8'h14 : 8'h17,
                {analog_in_en, port2_oe[3:2], port2_out[2], osc_in_clk});
        end
        $display("test alternate done");
    endtask : t_alt

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        chk("pulldown rst", 8'h01, {7'h0, osc_pins_pulldown_en});
        chk("oe rst", 8'h00, {3'h0, port3_io_oe, port2_oe} | port4_oe);
        rst <= 1'h0;
        t_port();
        t_port3();
        t_irq();
        t_alt();
        final_report();
    end

    initial begin
        #100000;
        fails++;
        final_report();
    end
endmodule : tb_pfm_port_mux

`default_nettype wire
